// ### rlc_pkg.sv
// shared constants and types for the rotate-left-through-carry datapath fragment
package rlc_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int FADDR_W = 8;
    localparam int QPHASE_N = 4;
    localparam logic [15:0] OPC_RLC_MASK = 16'hfe00;
    localparam logic [15:0] OPC_RLC_VAL = 16'h1a00;
    localparam logic [15:0] OPC_RETURN = 16'h0002;
    localparam int DEST_BIT = 8;
    localparam logic [7:0] PCLOW_ADDR = 8'h02;
    localparam logic [7:0] PCHIGH_ADDR = 8'h03;
    localparam logic [7:0] WORKREG_RST = 8'h00;
    localparam logic [7:0] PCLATCH_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic CARRY_RST = 1'b0;
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;
    typedef enum logic [1:0] {OP_NONE, OP_RLC, OP_RET} op_type;
endpackage

// ### quarter_gen.sv
// quarter-phase generator: cycles q1..q4, one core_clk per quarter
`timescale 1ns/1ns
module quarter_gen
    import rlc_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic rstn, // async reset, active low
    output logic [1:0] phase // current quarter
);
    typedef struct packed
    {
        logic [1:0] q;
    } qstate_type;
    qstate_type st_r;
    qstate_type st_nxt;

    // free-running modulo-4 counter
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.q = st_r.q + 2'h1;
    end

    // phase register; reset parks it on q1 so the first decode follows release
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            st_r <= '{q: Q1};
        else
            st_r <= st_nxt;
    end

    assign phase = st_r.q;
endmodule

// ### rlc_unit.sv
// rotate-left-through-carry datapath with return and pc low-byte read side effects
// Summary of operation
// - rotate shifts source left one, old carry into bit 0, old msb into carry
// - destination bit clear: result goes to working register, file untouched
// - destination bit set: result written back to the source file register
// - every read of pc low byte also refreshes the pc high latch
// - on return, the latch gets the upper address of the return instruction
// - completing a return loads the program counter from the stack top
`timescale 1ns/1ns
module rlc_unit
    import rlc_pkg::*;
(
    input wire logic core_clk, // core clock, 250 MHz
    input wire logic rstn, // async reset, active low
    input wire logic [15:0] instr, // instruction word, held for the instruction cycle
    input wire logic instr_valid, // instr holds a new instruction this cycle
    input wire logic [15:0] instr_addr, // address of instr in program memory
    input wire logic [15:0] stack_top, // top of return stack
    input wire logic [7:0] file_rdata, // file register read data, same cycle
    output logic [7:0] file_addr, // file register address
    output logic file_we, // file write strobe, one cycle in the q1 after the q4 decision
    output logic [7:0] file_wdata, // file write data
    output logic [7:0] working_register, // working register value
    output logic carry, // carry flag
    output logic [7:0] pc_high_latch, // high pc latch
    output logic [15:0] pc, // program counter
    output logic stack_pop, // one-cycle pop pulse on return
    output logic [1:0] phase, // current quarter
    output logic busy // instruction in progress
);
    import rlc_pkg::*;

    typedef struct packed
    {
        op_type op;
        logic [7:0] faddr;
        logic dest;
        logic [7:0] src;
        logic [7:0] res;
        logic cout;
        logic ret_second;
        logic [15:0] iaddr;
        logic [7:0] wacc; // working register contents
        logic c;
        logic [7:0] latch;
        logic [15:0] pc;
        logic we;
        logic [7:0] wdata;
        logic pop;
    } core_type;

    core_type st_r;
    core_type st_nxt;
    logic [1:0] q;

    // msb lands on top of the result, so the new carry is a plain slice
    function automatic logic [8:0] rot_left(input logic [7:0] v, input logic cin);
        rot_left = {v[7], v[6:0], cin};
    endfunction

    quarter_gen u_quarter
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .phase(q)
    );

    // one quarter per clock; decode waits for q1
    always_comb
    begin
        logic [8:0] r;
        r = 9'h000;
        st_nxt = st_r;
        st_nxt.we = 1'b0;
        st_nxt.pop = 1'b0;
        case (q)
            Q1:
            begin
                // second cycle of a return is a forced nop; first decode otherwise
                if (st_r.ret_second)
                    st_nxt.op = OP_RET;
                else if (instr_valid && ((instr & OPC_RLC_MASK) == OPC_RLC_VAL))
                begin
                    st_nxt.op = OP_RLC;
                    st_nxt.faddr = instr[7:0];
                    st_nxt.dest = instr[DEST_BIT];
                end
                else if (instr_valid && instr == OPC_RETURN)
                begin
                    st_nxt.op = OP_RET;
                    st_nxt.faddr = PCLOW_ADDR;
                    st_nxt.iaddr = instr_addr;
                end
                else
                    st_nxt.op = OP_NONE;
            end
            Q2:
            begin
                if (st_r.op == OP_RLC)
                    st_nxt.src = file_rdata;
                // the implied pc low read of a return updates the latch
                if (st_r.op == OP_RET && !st_r.ret_second)
                    st_nxt.latch = st_r.iaddr[15:8];
                // an explicit rotate read of pc low also refreshes the latch
                if (st_r.op == OP_RLC && st_r.faddr == PCLOW_ADDR)
                    st_nxt.latch = st_r.pc[15:8];
            end
            Q3:
            begin
                if (st_r.op == OP_RLC)
                begin
                    r = rot_left(st_r.src, st_r.c);
                    st_nxt.res = r[7:0];
                    st_nxt.cout = r[8];
                end
            end
            default:
            begin
                if (st_r.op == OP_RLC)
                begin
                    st_nxt.c = st_r.cout;
                    if (st_r.dest)
                    begin
                        st_nxt.we = 1'b1;
                        st_nxt.wdata = st_r.res;
                    end
                    else
                        st_nxt.wacc = st_r.res;
                end
                if (st_r.op == OP_RET)
                begin
                    st_nxt.ret_second = !st_r.ret_second;
                    if (st_r.ret_second)
                    begin
                        st_nxt.pc = stack_top;
                        st_nxt.pop = 1'b1;
                    end
                end
                else
                    st_nxt.pc = (st_r.op == OP_RLC) ? st_r.pc + 16'h0001 : st_r.pc;
                st_nxt.op = OP_NONE;
            end
        endcase
    end

    // state register; every field resets together so nothing starts unknown
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= '0;
            st_r.op <= OP_NONE;
            st_r.wacc <= WORKREG_RST;
            st_r.c <= CARRY_RST;
            st_r.latch <= PCLATCH_RST;
            st_r.pc <= PC_RST;
        end
        else
            st_r <= st_nxt;
    end

    // write strobe is a flop, so it appears in the cycle after q4 decision
    assign file_addr = st_r.faddr;
    assign file_we = st_r.we;
    assign file_wdata = st_r.wdata;
    assign working_register = st_r.wacc;
    assign carry = st_r.c;
    assign pc_high_latch = st_r.latch;
    assign pc = st_r.pc;
    assign stack_pop = st_r.pop;
    assign phase = q;
    assign busy = (st_r.op != OP_NONE) || st_r.ret_second;

    // result checks rebuild the rotate from its operands rather than trusting rot_left
    AST_ROT_CARRY: assert property (@(posedge core_clk) disable iff (!rstn)
        (q == Q4 && st_r.op == OP_RLC) |=> carry == $past(st_r.src[7]))
        else $error("carry not old msb after rotate");
    AST_ROT_W: assert property (@(posedge core_clk) disable iff (!rstn)
        (q == Q4 && st_r.op == OP_RLC && !st_r.dest) |=> !file_we
        && working_register == {$past(st_r.src[6:0]), $past(st_r.c)})
        else $error("working register result wrong");
    AST_ROT_F: assert property (@(posedge core_clk) disable iff (!rstn)
        (q == Q4 && st_r.op == OP_RLC && st_r.dest) |=> file_we
        && file_wdata == {$past(st_r.src[6:0]), $past(st_r.c)})
        else $error("file write back wrong");
    AST_PCL_LATCH: assert property (@(posedge core_clk) disable iff (!rstn)
        (q == Q2 && st_r.op == OP_RLC && st_r.faddr == PCLOW_ADDR) |=> pc_high_latch == $past(pc[15:8]))
        else $error("latch not refreshed on pc low read");
    AST_RET_LATCH: assert property (@(posedge core_clk) disable iff (!rstn)
        (q == Q2 && st_r.op == OP_RET && !st_r.ret_second) |=> pc_high_latch == $past(st_r.iaddr[15:8]))
        else $error("latch not return address high");
    AST_RET_PC: assert property (@(posedge core_clk) disable iff (!rstn)
        (q == Q4 && st_r.ret_second) |=> pc == $past(stack_top) && stack_pop)
        else $error("pc not loaded from stack top");
    AST_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (!rstn)
        (q == Q1 && st_nxt.op == OP_RLC) |=> ##2 st_r.op == OP_RLC ##1 st_r.op == OP_NONE)
        else $error("rotate not one instruction cycle");
    AST_WE_Q: assert property (@(posedge core_clk) disable iff (!rstn)
        file_we |-> q == Q1)
        else $error("file write outside instruction boundary");
    COV_ROT_W: cover property (@(posedge core_clk) disable iff (!rstn) q == Q4 && st_r.op == OP_RLC && !st_r.dest);
    COV_ROT_F: cover property (@(posedge core_clk) disable iff (!rstn) q == Q4 && st_r.op == OP_RLC && st_r.dest);
    COV_RET: cover property (@(posedge core_clk) disable iff (!rstn) stack_pop);
    AST_ROT_PC: assert property (@(posedge core_clk) disable iff (!rstn)
        (q == Q4 && st_r.op == OP_RLC) |=> pc == $past(pc) + 16'h0001)
        else $error("rotate did not advance pc by one word");
    AST_RET_TWO: assert property (@(posedge core_clk) disable iff (!rstn)
        (q == Q1 && st_nxt.op == OP_RET && !st_r.ret_second) |=> ##3 st_r.ret_second ##4 stack_pop)
        else $error("return did not take two instruction cycles");
    AST_RET_KEEP: assert property (@(posedge core_clk) disable iff (!rstn)
        (q == Q4 && st_r.op == OP_RET) |=> !file_we && carry == $past(carry)
        && working_register == $past(working_register))
        else $error("return disturbed working register, carry or file");
    AST_POP_ONE: assert property (@(posedge core_clk) disable iff (!rstn)
        stack_pop |=> !stack_pop)
        else $error("stack pop longer than one cycle");
    AST_LATCH_SRC: assert property (@(posedge core_clk) disable iff (!rstn)
        !$stable(pc_high_latch) |-> q == Q3 && $past(st_r.faddr) == PCLOW_ADDR)
        else $error("pc high latch changed without a pc low read");
    // the pc low read by a rotate is the rarer path, so it gets a cover of its own
    COV_PCL_READ: cover property (@(posedge core_clk) disable iff (!rstn)
        q == Q2 && st_r.op == OP_RLC && st_r.faddr == PCLOW_ADDR);
endmodule

// ### test_rlc_unit.sv
// self-checking testbench for the rotate-through-carry unit and its return side effects
`timescale 1ns/1ns
module test_rlc_unit;
    import rlc_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic instr_valid = 1'b0;
    logic [15:0] instr_addr = 16'h0000;
    logic [15:0] stack_top = 16'h5678;
    logic [7:0] file_rdata = 8'h00;
    logic [7:0] file_addr, file_wdata, working_register, pc_high_latch;
    logic file_we, carry, stack_pop, busy;
    logic [15:0] pc;
    logic [1:0] phase;
    int failures = 0;
    int checked = 0;

    rlc_unit dut_u (.core_clk(core_clk), .rstn(rstn), .instr(instr), .instr_valid(instr_valid),
        .instr_addr(instr_addr), .stack_top(stack_top), .file_rdata(file_rdata), .file_addr(file_addr),
        .file_we(file_we), .file_wdata(file_wdata), .working_register(working_register), .carry(carry),
        .pc_high_latch(pc_high_latch), .pc(pc), .stack_pop(stack_pop), .phase(phase), .busy(busy));

    // 250 MHz core clock
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    // compare tasks; unknown bits count as a mismatch
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask

    // present one instruction at the next q1, return just after the edge that closes its q4;
    // write strobe and pop stand for that one q1 only, so results are looked at there
    task automatic issue(input logic [15:0] op, input logic [7:0] src, input logic [15:0] addr);
        @(posedge core_clk);
        #1;
        while (phase !== Q1)
        begin
            @(posedge core_clk);
            #1;
        end
        instr = op;
        instr_addr = addr;
        file_rdata = src; // held through q2 so the read sees it
        instr_valid = 1'b1;
        @(posedge core_clk);
        #1;
        instr_valid = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // rotate into working register: example operand, old carry clear
    task automatic rot_to_working_register();
        issue(16'h1a25, 8'he6, 16'h0010);
        chk_val({8'h00, working_register}, 16'h00cc);
        chk_bit(carry, 1'b1);
        chk_bit(file_we, 1'b0);
        chk_val(pc, 16'h0001);
        chk_val({14'h0000, phase}, {14'h0000, Q1});
        chk_bit(busy, 1'b0);
    endtask

    // rotate back to file: msb out, set carry shifts into bit zero
    task automatic rot_to_file();
        issue(16'h1b40, 8'h80, 16'h0011);
        chk_bit(file_we, 1'b1);
        chk_val({8'h00, file_addr}, 16'h0040);
        chk_val({8'h00, file_wdata}, 16'h0001);
        chk_val({8'h00, working_register}, 16'h00cc);
        chk_bit(carry, 1'b1);
        @(posedge core_clk);
        #1;
        chk_bit(file_we, 1'b0);
        issue(16'h1a11, 8'h01, 16'h0012);
        chk_val({8'h00, working_register}, 16'h0003);
        chk_bit(carry, 1'b0);
        chk_val(pc, 16'h0003);
    endtask

    // return: latch gets the return's own high address, pc loads from stack top one instruction cycle later;
    // a rotate offered in the forced nop cycle must be ignored
    task automatic do_return();
        issue(OPC_RETURN, 8'h00, 16'h1234);
        chk_val({8'h00, pc_high_latch}, 16'h0012);
        chk_bit(stack_pop, 1'b0);
        chk_val(pc, 16'h0003);
        chk_bit(busy, 1'b1);
        instr = 16'h1a01;
        file_rdata = 8'hff;
        instr_valid = 1'b1;
        @(posedge core_clk);
        #1;
        instr_valid = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk_bit(stack_pop, 1'b1);
        chk_val(pc, 16'h5678);
        chk_val({8'h00, working_register}, 16'h0003);
        chk_bit(carry, 1'b0);
        @(posedge core_clk);
        #1;
        chk_bit(stack_pop, 1'b0);
    endtask

    // rotate reading the pc low byte refreshes the high latch from the pc
    task automatic rot_pc_low();
        issue(16'h1a02, 8'h78, 16'h5678);
        chk_val({8'h00, pc_high_latch}, 16'h0056);
        chk_val({8'h00, working_register}, 16'h00f0);
        chk_bit(carry, 1'b0);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial
    begin
        #20000;
        failures++;
        complete_run();
    end

    initial
    begin
        repeat (5) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        chk_val(pc, PC_RST);
        chk_val({8'h00, working_register}, {8'h00, WORKREG_RST});
        rot_to_working_register();
        rot_to_file();
        do_return();
        rot_pc_low();
        complete_run();
    end
endmodule
